// file: bench/rtm_tag_model.sv
// Tag engine stand-in that answers reads with block-coded data
`timescale 1ns/1ps
`default_nettype none
module rtm_tag_model
  import rtm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Read request side
  input wire logic read_req_i,
  input wire logic [7:0] start_i,
  input wire logic [9:0] idx_i,
  input wire logic found_i,
  input wire logic [7:0] flags_i,
  // Answer side
  output var rtm_tag_ans_type ans_o,
  output logic [7:0] data_o
);
  logic [3:0] wait_q;
  // Byte i belongs to block start+(i/4 mod 64), from idx bits 7:2, coded as an ASCII digit
  assign data_o = 8'h30 + start_i + {2'h0, idx_i[7:2]};
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q <= '0;
      ans_o <= '0;
    end else begin
      ans_o <= '0;
      if (read_req_i) begin
        wait_q <= 4'h6;
      end else if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
        // A missing tag never answers, so the reader must time out
        if (wait_q == 4'h1 && found_i) begin
          ans_o <= '{done: 1'b1, found: 1'b1, flags: flags_i};
        end
      end
    end
  end
endmodule : rtm_tag_model
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench of the trigger-mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtm_pkg::*;
  localparam int TC = 20;
  logic clk_i = 0, nrst_i = 0, rx_valid_i = 0, rx_port_i = 0;
  logic tx_ready_i = 0, found = 1;
  logic [7:0] flags = 8'h00;
  logic [1:0] trig_i = '0;
  logic [7:0] rx_byte_i = '0;
  logic [2:0] rx_rate_i = '0;
  rtm_cfg_type cfg_i = '0;
  logic trigger_mode_o, setup_mode_o, read_req_o, tx_valid_o;
  logic [1:0] out_o, read_ant_o;
  logic [7:0] read_start_o, tx_byte_o, tag_data_i;
  logic [9:0] data_idx_o;
  rtm_tag_ans_type tag_i;
  int num_errors = 0, cmp_count = 0, cyc = 0, reqs = 0;
  int t_req = 0, t_tx = 0;
  logic [7:0] got[$], ex[$];

  always #10 clk_i = ~clk_i;

  rtm_trigger_ctrl #(.TRIG_CYC(TC), .TICK_LEN(10)) dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .cfg_i(cfg_i), .setup_exit_i(1'b0),
    .trigger_mode_o(trigger_mode_o), .setup_mode_o(setup_mode_o),
    .trig_i(trig_i), .out_o(out_o), .rx_valid_i(rx_valid_i),
    .rx_byte_i(rx_byte_i), .rx_port_i(rx_port_i), .rx_rate_i(rx_rate_i),
    .read_req_o(read_req_o), .read_ant_o(read_ant_o),
    .read_start_o(read_start_o), .data_idx_o(data_idx_o), .tag_i(tag_i),
    .tag_data_i(tag_data_i), .tx_valid_o(tx_valid_o),
    .tx_byte_o(tx_byte_o), .tx_ready_i(tx_ready_i));

  rtm_tag_model tag_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .read_req_i(read_req_o),
    .start_i(read_start_o), .idx_i(data_idx_o), .found_i(found),
    .flags_i(flags),
    .ans_o(tag_i), .data_o(tag_data_i));

  // Sink stalls every other cycle to exercise the hold of tx bytes
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    tx_ready_i <= ~tx_ready_i;
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) got.push_back(tx_byte_o);
    if (read_req_o === 1'b1) reqs <= reqs + 1;
    // Cycle of the last launch and of the first byte after it
    if (read_req_o === 1'b1) t_req <= cyc;
    if (tx_valid_o === 1'b1 && t_tx < t_req) t_tx <= cyc;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic finish_test();
    $display("Counts: %0d compares, %0d errors", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic fire(input int n, input int len);
    @(posedge clk_i) trig_i <= trig_i | (2'b01 << n);
    repeat (len) @(posedge clk_i);
    trig_i <= trig_i & ~(2'b01 << n);
  endtask : fire

  task automatic expect_frame(input int n, input int nblk, input logic ok);
    logic [7:0] nt[6];
    nt = '{8'h4e, 8'h4f, 8'h20, 8'h54, 8'h41, 8'h47};
    ex.delete();
    if (cfg_i.transmit_lead_byte != 8'h00)
      ex.push_back(cfg_i.transmit_lead_byte);
    if (cfg_i.antenna_select_setting != 2'h0) ex.push_back(8'h30 + 8'(n + 1));
    if (ok) begin
      ex.push_back(flags);
      for (int b = 0; b < nblk; b++)
        repeat (4) ex.push_back(8'h30 + 8'(b));
    end else begin
      foreach (nt[i]) ex.push_back(nt[i]);
    end
    if (cfg_i.transmit_tail_byte != 8'h00)
      ex.push_back(cfg_i.transmit_tail_byte);
  endtask : expect_frame

  task automatic frame(input int n, input string name);
    got.delete();
    fire(n, TC + 4);
    for (int i = 0; i < 400 && got.size() < ex.size(); i++) @(posedge clk_i);
    repeat (20) @(posedge clk_i);
    chk(16'(got.size()), 16'(ex.size()));
    foreach (ex[i]) chk({8'h00, got[i]}, {8'h00, ex[i]});
    $display("Test %s done", name);
  endtask : frame

  task automatic send_word(input logic p, input logic [2:0] r, input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk_i);
      rx_valid_i <= 1'b1;
      rx_byte_i <= s[i];
      rx_port_i <= p;
      rx_rate_i <= r;
      @(posedge clk_i) rx_valid_i <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
  endtask : send_word

  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(trigger_mode_o, 1'b0);
    fire(0, TC + 4);
    repeat (20) @(posedge clk_i);
    chk(16'(reqs), 16'h0);
    $display("Test idle done");
    @(posedge clk_i);
    cfg_i.second_trigger_action <= 2'h1;
    cfg_i.trigger_timeout_setting <= 8'h05;
    repeat (3) @(posedge clk_i);
    chk(trigger_mode_o, 1'b1);
    cfg_i.first_trigger_action <= 2'h2;
    cfg_i.antenna_select_setting <= ANT_TRIG_SW;
    cfg_i.transmit_lead_byte <= 8'h5b;
    cfg_i.transmit_tail_byte <= 8'h5d;
    cfg_i.first_output_map <= 2'h1;
    cfg_i.second_output_map <= 2'h3;
    cfg_i.port_select_setting <= 1'b1;
    cfg_i.line_rate_setting <= 3'h3;
    @(posedge clk_i);
    expect_frame(0, 1, 1'b1);
    frame(0, "trigger one");
    chk(out_o, 2'h1);
    cfg_i.block_count <= 8'h04;
    @(posedge clk_i);
    expect_frame(1, 5, 1'b1);
    frame(1, "five blocks");
    chk(out_o, 2'h3);
    found <= 1'b0;
    cfg_i.block_count <= 8'h00;
    @(posedge clk_i);
    expect_frame(0, 0, 1'b0);
    frame(0, "no tag");
    chk(out_o, 2'h0);
    // Five timeout units of ten ticks, plus the first byte's load
    chk(16'(t_tx - t_req > 49 && t_tx - t_req < 53), 16'h1);
    found <= 1'b1;
    flags <= 8'h13;
    cfg_i.transmit_lead_byte <= 8'h00;
    cfg_i.transmit_tail_byte <= 8'h00;
    cfg_i.antenna_select_setting <= 2'h0;
    @(posedge clk_i);
    expect_frame(0, 1, 1'b1);
    frame(0, "bare frame");
    reqs = 0;
    fire(0, TC - 1);
    repeat (30) @(posedge clk_i);
    chk(16'(reqs), 16'h0);
    $display("Test short trigger done");
    send_word(1'b0, 3'h3, "setup");
    send_word(1'b1, 3'h2, "setup");
    chk(setup_mode_o, 1'b0);
    send_word(1'b1, 3'h3, "xsetu");
    chk(setup_mode_o, 1'b0);
    send_word(1'b1, 3'h3, "setup");
    chk(setup_mode_o, 1'b1);
    chk(trigger_mode_o, 1'b0);
    chk(16'(reqs), 16'h0);
    $display("Test setup entry done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire

// file: common/rtm_pkg.sv
// Shared constants, types and helpers of the trigger-mode controller
package rtm_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TRIG_MIN_MS = 10;
  localparam int TRIG_MIN_CYC = (CLK_HZ / 1000) * TRIG_MIN_MS;
  localparam int TICK_MS = 10;
  localparam int TICK_CYC = (CLK_HZ / 1000) * TICK_MS;
  localparam logic [7:0] TOUT_DEF = 8'h05;
  localparam logic [7:0] TOUT_MIN = 8'h05;
  localparam logic [7:0] ISO_OK = 8'h00;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [1:0] ANT_TRIG_SW = 2'h1;
  localparam logic [2:0] NOTAG_LEN = 3'h6;
  localparam logic [2:0] SETUP_LEN = 3'h5;
  localparam logic [9:0] BLOCK_BYTES = 10'h004;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_HDR = 3'b011,
    ST_ANT = 3'b010,
    ST_FLAG = 3'b110,
    ST_DATA = 3'b111,
    ST_NOTAG = 3'b101,
    ST_TRL = 3'b100
  } rtm_state_type;

  typedef struct packed {
    logic [1:0] first_trigger_action;
    logic [1:0] second_trigger_action;
    logic [1:0] antenna_select_setting;
    logic port_select_setting;
    logic [2:0] line_rate_setting;
    logic [7:0] transmit_lead_byte;
    logic [7:0] transmit_tail_byte;
    logic [7:0] trigger_timeout_setting;
    logic [7:0] start_block;
    logic [7:0] block_count;
    logic [1:0] first_output_map;
    logic [1:0] second_output_map;
  } rtm_cfg_type;

  typedef struct packed {
    logic done;
    logic found;
    logic [7:0] flags;
  } rtm_tag_ans_type;

  function automatic logic [7:0] notag_char(input logic [2:0] idx);
    case (idx)
      3'h0: notag_char = 8'h4e;
      3'h1: notag_char = 8'h4f;
      3'h2: notag_char = 8'h20;
      3'h3: notag_char = 8'h54;
      3'h4: notag_char = 8'h41;
      default: notag_char = 8'h47;
    endcase
  endfunction : notag_char

  function automatic logic [7:0] setup_char(input logic [2:0] idx);
    case (idx)
      3'h0: setup_char = 8'h73;
      3'h1: setup_char = 8'h65;
      3'h2: setup_char = 8'h74;
      3'h3: setup_char = 8'h75;
      default: setup_char = 8'h70;
    endcase
  endfunction : setup_char
endpackage : rtm_pkg

// file: design/rtm_trigger_ctrl.sv
// Trigger-mode controller: trigger qualify, read launch, response framing
//
// Contract
// RULE1 - Trigger mode when either action is nonzero
// RULE2 - In trigger mode only triggers start reads
// RULE3 - Discard all serial input except setup string
// RULE4 - Setup string leaves trigger mode for setup
// RULE5 - Setup string only on selected port, rate
// RULE6 - Trigger-switched mode: trigger N picks antenna N
// RULE7 - Trigger must stay active at least 10ms
// RULE8 - Each trigger maps to either or both outputs
// RULE9 - Frame: lead, antenna digit, flags, data, tail
// RULE10 - Missed tag: NO TAG replaces flags and data
// RULE11 - No separators; absent fields send nothing
// RULE12 - Count 04 returns blocks 0..4 ascending
// RULE13 - Default settings return block 0 only
// RULE14 - Timeout counts 10ms units, minimum 005
// RULE15 - Lead and tail bytes sent only if nonzero
// RULE16 - Antenna digit only in dual-antenna modes
// RULE17 - Nonzero flag byte carries tag error code
// RULE18 - Synchronise, count, one event per activation
`timescale 1ns/1ps
`default_nettype none
module rtm_trigger_ctrl
  import rtm_pkg::*;
#(
  parameter int TRIG_CYC = TRIG_MIN_CYC,
  parameter int TICK_LEN = TICK_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Settings and mode
  input wire rtm_cfg_type cfg_i,
  input wire logic setup_exit_i,
  output logic trigger_mode_o,
  output logic setup_mode_o,
  // Trigger pins and discrete outputs
  input wire logic [1:0] trig_i,
  output logic [1:0] out_o,
  // Serial receive
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_port_i,
  input wire logic [2:0] rx_rate_i,
  // Tag engine
  output logic read_req_o,
  output logic [1:0] read_ant_o,
  output logic [7:0] read_start_o,
  output logic [9:0] data_idx_o,
  input wire rtm_tag_ans_type tag_i,
  input wire logic [7:0] tag_data_i,
  // Serial transmit
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  input wire logic tx_ready_i
);
  localparam int CW = $clog2(TRIG_CYC + 1);
  localparam int TW = $clog2(TICK_LEN + 1);
  localparam logic [CW-1:0] TRIG_LAST = CW'(TRIG_CYC - 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_LEN - 1);
  logic [1:0] sync1_q, sync2_q;
  logic [CW-1:0] cnt_q [2];
  logic [1:0] armed_q, event_q, pend_q;
  logic [TW-1:0] tick_q;
  logic [7:0] tout_q;
  logic [2:0] rx_idx_q;
  logic [2:0] nt_idx_q;
  logic [7:0] flags_q;
  logic found_q, src_q;
  rtm_state_type state_q, state_d;
  // Mode decode
  wire act_w = (cfg_i.first_trigger_action != 2'h0) ||
               (cfg_i.second_trigger_action != 2'h0); // [RULE1]
  wire tmode_w = act_w && !setup_mode_o;
  wire dual_w = cfg_i.antenna_select_setting != 2'h0; // [RULE16]
  wire lead_w = cfg_i.transmit_lead_byte != 8'h00; // [RULE15]
  wire tail_w = cfg_i.transmit_tail_byte != 8'h00; // [RULE15]
  // Serial filter: wrong port or rate never advances the matcher
  wire rx_ok_w = rx_valid_i && tmode_w &&
                 (rx_port_i == cfg_i.port_select_setting) &&
                 (rx_rate_i == cfg_i.line_rate_setting); // [RULE5]
  wire rx_hit_w = rx_ok_w && (rx_byte_i == setup_char(rx_idx_q));
  wire rx_first_w = rx_ok_w && (rx_byte_i == setup_char(3'h0));
  wire setup_done_w = rx_hit_w && (rx_idx_q == SETUP_LEN - 3'h1); // [RULE4]
  // Read launch: trigger 1 wins a tie, the other stays pending
  wire idle_w = state_q == ST_IDLE;
  wire take_w = idle_w && tmode_w && (pend_q != 2'b00); // [RULE2]
  wire take_src_w = !pend_q[0];
  wire [7:0] tout_set_w = (cfg_i.trigger_timeout_setting < TOUT_MIN) ?
                          TOUT_MIN : cfg_i.trigger_timeout_setting;
  wire expire_w = (tout_q == 8'h00) && (tick_q == TICK_LAST); // [RULE14]
  wire fin_w = state_q == ST_WAIT && (tag_i.done || expire_w);
  wire fin_found_w = tag_i.done && tag_i.found;
  // Response length: (count + 1) blocks of four bytes, ascending
  wire [9:0] len_w = {cfg_i.block_count, 2'b00} + BLOCK_BYTES; // [RULE12]
  wire load_w = !tx_valid_o || tx_ready_i;
  wire emit_w = !(idle_w || state_q == ST_WAIT);
  wire data_last_w = data_idx_o == len_w - 10'h001;
  wire nt_last_w = nt_idx_q == NOTAG_LEN - 3'h1;
  // Byte for the current field; no separators anywhere
  wire [7:0] ant_char_w = ASCII_ZERO + {6'h00, read_ant_o};
  wire [7:0] byte_w =
    (state_q == ST_HDR) ? cfg_i.transmit_lead_byte :
    (state_q == ST_ANT) ? ant_char_w :
    (state_q == ST_FLAG) ? flags_q :
    (state_q == ST_DATA) ? tag_data_i :
    (state_q == ST_NOTAG) ? notag_char(nt_idx_q) :
    cfg_i.transmit_tail_byte; // [RULE11]
  // Next field after the antenna digit slot
  function automatic rtm_state_type after_ant(input logic found);
    after_ant = found ? ST_FLAG : ST_NOTAG;
  endfunction : after_ant
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (take_w) state_d = ST_WAIT;
      ST_WAIT: begin
        if (fin_w) begin
          if (lead_w) state_d = ST_HDR;
          else if (dual_w) state_d = ST_ANT;
          else state_d = after_ant(fin_found_w);
        end
      end
      ST_HDR: if (load_w) state_d = dual_w ? ST_ANT : after_ant(found_q);
      ST_ANT: if (load_w) state_d = after_ant(found_q);
      ST_FLAG: if (load_w) state_d = ST_DATA; // [RULE9]
      ST_DATA: begin
        if (load_w && data_last_w) state_d = tail_w ? ST_TRL : ST_IDLE;
      end
      ST_NOTAG: begin
        if (load_w && nt_last_w) state_d = tail_w ? ST_TRL : ST_IDLE;
      end
      ST_TRL: if (load_w) state_d = ST_IDLE;
    endcase
  end
  // Trigger qualification
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q <= 2'b00;
      sync2_q <= 2'b00;
      armed_q <= 2'b11;
      event_q <= 2'b00;
      for (int i = 0; i < 2; i++) cnt_q[i] <= '0;
    end else begin
      sync1_q <= trig_i;
      sync2_q <= sync1_q;
      for (int i = 0; i < 2; i++) begin
        event_q[i] <= 1'b0;
        if (!sync2_q[i]) begin
          cnt_q[i] <= '0;
          armed_q[i] <= 1'b1;
        end else if (armed_q[i] && cnt_q[i] == TRIG_LAST) begin
          event_q[i] <= 1'b1; // [RULE7] [RULE18]
          armed_q[i] <= 1'b0;
        end else if (armed_q[i]) begin
          cnt_q[i] <= cnt_q[i] + CW'(1);
        end
      end
    end
  end
  // Pending triggers; a new event beats the clear in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) pend_q <= 2'b00;
    else if (!tmode_w) pend_q <= 2'b00; // [RULE2]
    else begin
      for (int i = 0; i < 2; i++) begin
        if (event_q[i]) pend_q[i] <= 1'b1;
        else if (take_w && take_src_w == i[0]) pend_q[i] <= 1'b0;
      end
    end
  end
  // Mode flags and setup matcher
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      setup_mode_o <= 1'b0;
      trigger_mode_o <= 1'b0;
      rx_idx_q <= 3'h0;
    end else begin
      trigger_mode_o <= tmode_w && !setup_done_w; // [RULE1]
      if (setup_done_w) setup_mode_o <= 1'b1; // [RULE4]
      else if (setup_exit_i) setup_mode_o <= 1'b0;
      if (setup_done_w) rx_idx_q <= 3'h0;
      else if (rx_hit_w) rx_idx_q <= rx_idx_q + 3'h1;
      else if (rx_ok_w) rx_idx_q <= rx_first_w ? 3'h1 : 3'h0; // [RULE3]
    end
  end
  // Read request, antenna choice and timeout
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      read_req_o <= 1'b0;
      read_ant_o <= 2'h1;
      read_start_o <= 8'h00;
      src_q <= 1'b0;
      tick_q <= '0;
      tout_q <= TOUT_DEF;
      found_q <= 1'b0;
      flags_q <= ISO_OK;
    end else begin
      read_req_o <= take_w; // [RULE2]
      if (take_w) begin
        src_q <= take_src_w;
        read_start_o <= cfg_i.start_block; // [RULE13]
        tout_q <= tout_set_w - 8'h01;
        tick_q <= '0;
        if (cfg_i.antenna_select_setting == ANT_TRIG_SW) begin
          read_ant_o <= take_src_w ? 2'h2 : 2'h1; // [RULE6]
        end
      end else if (state_q == ST_WAIT) begin
        tick_q <= (tick_q == TICK_LAST) ? '0 : tick_q + TW'(1);
        if (tick_q == TICK_LAST && tout_q != 8'h00) begin
          tout_q <= tout_q - 8'h01; // [RULE14]
        end
      end
      if (fin_w) begin
        found_q <= fin_found_w; // [RULE10]
        flags_q <= tag_i.flags; // [RULE17]
      end
    end
  end

  // Discrete outputs: levels held from a good read to the next launch
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) out_o <= 2'b00;
    else if (take_w) out_o <= 2'b00;
    else if (fin_w && fin_found_w) begin
      out_o <= src_q ? cfg_i.second_output_map :
                       cfg_i.first_output_map; // [RULE8]
    end
  end

  // Framer: output byte register refilled as the sink drains it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      tx_valid_o <= 1'b0;
      tx_byte_o <= 8'h00;
      data_idx_o <= 10'h000;
      nt_idx_q <= 3'h0;
    end else begin
      state_q <= state_d;
      if (load_w && emit_w) begin
        tx_valid_o <= 1'b1;
        tx_byte_o <= byte_w; // [RULE9]
      end else if (tx_ready_i) begin
        tx_valid_o <= 1'b0;
      end
      if (take_w) begin
        data_idx_o <= 10'h000;
        nt_idx_q <= 3'h0;
      end else if (load_w && state_q == ST_DATA) begin
        data_idx_o <= data_idx_o + 10'h001; // [RULE12]
      end else if (load_w && state_q == ST_NOTAG) begin
        nt_idx_q <= nt_idx_q + 3'h1; // [RULE10]
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  trig_mode_a: assert property (trigger_mode_o |-> $past(act_w)) // [RULE1]
    else $error("trigger mode without nonzero action");
  read_source_a: assert property ( // [RULE2]
    read_req_o |-> $past(pend_q != 2'b00) && $past(tmode_w))
    else $error("read launched without qualified trigger");
  rx_discard_a: assert property ( // [RULE3]
    (rx_ok_w && !rx_hit_w && !rx_first_w) |=> rx_idx_q == 3'h0)
    else $error("stray byte kept setup matcher state");
  setup_entry_a: assert property ( // [RULE4]
    setup_done_w |=> setup_mode_o && !trigger_mode_o)
    else $error("setup string did not enter setup mode");
  port_rate_a: assert property ( // [RULE5]
    (rx_valid_i && (rx_port_i != cfg_i.port_select_setting ||
    rx_rate_i != cfg_i.line_rate_setting)) |=> $stable(rx_idx_q))
    else $error("matcher moved on wrong port or rate");
  ant_switch_a: assert property ( // [RULE6]
    (read_req_o && cfg_i.antenna_select_setting == ANT_TRIG_SW) |->
    read_ant_o == {src_q, !src_q})
    else $error("antenna does not follow trigger");
  qualify_a: assert property ( // [RULE7]
    event_q[0] |-> $past(sync2_q[0], 2) && $past(cnt_q[0]) == TRIG_LAST)
    else $error("trigger accepted before minimum time");
  lead_skip_a: assert property ( // [RULE15]
    (state_q == ST_HDR) |-> lead_w)
    else $error("lead byte sent while zero");
  notag_a: assert property ( // [RULE10]
    (state_q == ST_NOTAG && load_w && nt_idx_q == 3'h0) |=>
    tx_valid_o && tx_byte_o == 8'h4e)
    else $error("missing tag message wrong");
  ant_field_a: assert property ((state_q == ST_ANT) |-> dual_w) // [RULE16]
    else $error("antenna digit outside dual mode");
endmodule : rtm_trigger_ctrl
`default_nettype wire
